// ===== bench/dsi_rx_term_and_pclk_divider_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dsi_rx_term_and_pclk_divider_cfg_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, dual = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hF, gap = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [1:0] lanes_m1 = 2'h0, bpp_m1 = 2'h0;
  logic [4:0] auto_te = 5'h00, term_en, v;
  logic ack, tick, pen;
  int n_errors = 0, checked = 0, pulses = 0, ticks = 0, m, n, d, p0, t0, e;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    pulses <= pulses + int'(pen === 1'b1);
    ticks <= ticks + int'(tick === 1'b1);
  end
  dsi_rx_term_pclk_cfg dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .lane_count_m1(lanes_m1),
    .bytes_per_pixel_m1(bpp_m1), .dual_input(dual), .auto_term_enable(auto_te), .serial_clk_tick(tick),
    .term_enable(term_en), .pclk_en(pen));
  serial_src_model src (.ref_clk(ref_clk), .rst_n(rst_n), .gap(gap), .tick(tick));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] dv);
    int t = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, dv};
    do begin
      @(posedge ref_clk);
      t++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack_wait", 32'h2, t);
  endtask
  task rate(input int mm, input int nn);
    repeat (39) @(posedge ref_clk);
    t0 = ticks;
    @(posedge ref_clk);
    p0 = pulses;
    repeat (299) @(posedge ref_clk);
    e = (ticks - t0) * mm / nn;
    @(posedge ref_clk);
    d = pulses - p0 - e;
    chk("pclk_rate", e, e + ((d < 2 && d > -2) ? 0 : d));
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 20000);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(97770));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Automatic selection
    repeat (4) begin
      {lanes_m1, bpp_m1, dual, auto_te} <= 10'($urandom);
      gap <= 4'($urandom % 3);
      repeat (3) @(posedge ref_clk);
      m = (lanes_m1 + 1) * (dual ? 2 : 1);
      n = bpp_m1 + 1;
      wb(1'b0, pclk_cfg_pkg::TERM_IDX, 8'h00);
      chk("term_rd", 32'h0, q);
      chk("term_auto", {27'h0, auto_te}, {27'h0, term_en});
      wb(1'b0, pclk_cfg_pkg::DIV_M_IDX, 8'h00);
      chk("m_auto", m, q);
      wb(1'b0, pclk_cfg_pkg::DIV_N_IDX, 8'h00);
      chk("n_auto", n, q);
      rate(m > n ? n : m, n);
    end
    $display("test auto done");
    // Software overrides
    repeat (3) begin
      v = 5'($urandom);
      wb(1'b1, pclk_cfg_pkg::TERM_IDX, {3'h2, v});
      wb(1'b0, pclk_cfg_pkg::TERM_IDX, 8'h00);
      chk("term_rd", {27'h2, v}, q);
      auto_te <= ~v;
      repeat (3) @(posedge ref_clk);
      chk("term_ovr", {27'h0, v}, {27'h0, term_en});
      n = 1 + $urandom % 8;
      m = $urandom % 9;
      wb(1'b1, pclk_cfg_pkg::DIV_N_IDX, 8'(n));
      wb(1'b1, pclk_cfg_pkg::DIV_M_IDX, 8'(8'h80 | m));
      wb(1'b0, pclk_cfg_pkg::DIV_M_IDX, 8'h00);
      chk("m_ovr", 32'h80 | m, q);
      wb(1'b0, pclk_cfg_pkg::DIV_N_IDX, 8'h00);
      chk("n_ovr", n, q);
      rate(m > n ? n : m, n);
    end
    wb(1'b1, pclk_cfg_pkg::DIV_M_IDX, 8'h00);
    wb(1'b0, pclk_cfg_pkg::DIV_M_IDX, 8'h00);
    chk("m_back", (lanes_m1 + 1) * (dual ? 2 : 1), q);
    wb(1'b0, 8'h3F, 8'h00);
    chk("unmapped", 32'h0, q);
    $display("test override done");
    tally_and_finish;
  end
endmodule // dsi_rx_term_and_pclk_divider_cfg_tb
`default_nettype wire

// ===== bench/serial_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_src_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] gap,
  output logic tick
);
  logic [3:0] cnt_reg;
  // One tick per serial clock period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == 4'h0);
      cnt_reg <= (cnt_reg == 4'h0) ? gap : cnt_reg - 4'h1;
    end
  end
endmodule // serial_src_model
`default_nettype wire

// ===== core/dsi_rx_term_pclk_cfg.sv
// Behaviour
// - Termination override bit, reset clear, makes lanes follow software enables.
// - Separate termination enables for clock lane and data lanes 0-3, reset zero.
// - Divider override is bit 7 of M; when set, software M and N used.
// - M setting is a five-bit field in bits 4-0, reset value hardware chosen.
// - Without override, M and N come from lanes, bytes per pixel, dual mode.
// - With override clear, reading M returns the automatic M value.
// - Pixel clock derived from serial clock through M/N divider, auto or override.
// - N is a separate eight-bit register; reads show auto value unless overridden.
`timescale 1ns/1ps
`default_nettype none
module dsi_rx_term_pclk_cfg (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] lane_count_m1,
  input wire logic [1:0] bytes_per_pixel_m1,
  input wire logic dual_input,
  input wire logic [4:0] auto_term_enable,
  input wire logic serial_clk_tick,
  output logic [4:0] term_enable,
  output logic pclk_en
);
  logic termination_override;
  logic [4:0] term_lanes_reg;
  logic divider_override;
  logic [4:0] div_m_reg;
  logic [7:0] div_n_reg;
  logic [4:0] auto_m;
  logic [7:0] auto_n;
  logic [4:0] sel_m;
  logic [7:0] sel_n;
  logic req;
  logic wr;
  logic [7:0] rd_byte;

  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    return adr == {idx, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////
  // Automatic divider choice
  assign auto_m = 5'({3'b000, lane_count_m1} + 5'h01) << dual_input;
  assign auto_n = {6'h00, bytes_per_pixel_m1} + 8'h01;
  assign sel_m = divider_override ? div_m_reg : auto_m;
  assign sel_n = divider_override ? div_n_reg : auto_n;

  ////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit(wb_adr_i, pclk_cfg_pkg::TERM_IDX)) begin
      rd_byte = {1'b0, termination_override, 1'b0, term_lanes_reg};
    end else if (hit(wb_adr_i, pclk_cfg_pkg::DIV_M_IDX)) begin
      rd_byte = {divider_override, 2'b00, sel_m};
    end else if (hit(wb_adr_i, pclk_cfg_pkg::DIV_N_IDX)) begin
      rd_byte = sel_n;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Termination register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      termination_override <= pclk_cfg_pkg::TERM_OVR_RESET;
      term_lanes_reg <= pclk_cfg_pkg::TERM_RESET;
    end else if (wr && hit(wb_adr_i, pclk_cfg_pkg::TERM_IDX)) begin
      termination_override <= wb_dat_i[pclk_cfg_pkg::TERM_OVR_BIT];
      term_lanes_reg <= wb_dat_i[pclk_cfg_pkg::TERM_LANES_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_enable <= 5'h00;
    end else begin
      term_enable <= termination_override ? term_lanes_reg : auto_term_enable;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Divider registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_override <= pclk_cfg_pkg::DIV_OVR_RESET;
      div_m_reg <= pclk_cfg_pkg::M_RESET;
    end else if (wr && hit(wb_adr_i, pclk_cfg_pkg::DIV_M_IDX)) begin
      divider_override <= wb_dat_i[pclk_cfg_pkg::DIV_OVR_BIT];
      div_m_reg <= wb_dat_i[pclk_cfg_pkg::M_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_n_reg <= pclk_cfg_pkg::N_RESET;
    end else if (wr && hit(wb_adr_i, pclk_cfg_pkg::DIV_N_IDX)) begin
      div_n_reg <= wb_dat_i[pclk_cfg_pkg::N_W-1:0];
    end
  end

  mn_divider u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_tick(serial_clk_tick),
    .m_in(sel_m),
    .n_in(sel_n),
    .pclk_en(pclk_en)
  );

  ////////////////////////////////////////////////////////////////
  property p_ack_one;
    @(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_term_follow;
    @(posedge ref_clk) disable iff (!rst_n)
    termination_override ##1 termination_override |-> term_enable == $past(term_lanes_reg);
  endproperty
  a_term_follow: assert property (p_term_follow) else $error("termination ignores override");

  property p_term_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && hit(wb_adr_i, pclk_cfg_pkg::TERM_IDX) |=> term_lanes_reg == $past(wb_dat_i[4:0]);
  endproperty
  a_term_write: assert property (p_term_write) else $error("lane enables not stored");

  property p_ovr_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && hit(wb_adr_i, pclk_cfg_pkg::DIV_M_IDX) && wb_dat_i[7] |=> divider_override && sel_m == div_m_reg;
  endproperty
  a_ovr_write: assert property (p_ovr_write) else $error("override not applied");

  property p_m_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && hit(wb_adr_i, pclk_cfg_pkg::DIV_M_IDX) |=> div_m_reg == $past(wb_dat_i[4:0]);
  endproperty
  a_m_write: assert property (p_m_write) else $error("M field not stored");

  property p_auto_sel;
    @(posedge ref_clk) disable iff (!rst_n)
    !divider_override |-> sel_m == 5'(({3'b000, lane_count_m1} + 5'h01) * (dual_input ? 5'h02 : 5'h01))
      && sel_n == {6'h00, bytes_per_pixel_m1} + 8'h01;
  endproperty
  a_auto_sel: assert property (p_auto_sel) else $error("automatic divider not used");

  property p_m_readback;
    @(posedge ref_clk) disable iff (!rst_n)
    req && !wb_we_i && hit(wb_adr_i, pclk_cfg_pkg::DIV_M_IDX) && !divider_override
      |=> wb_ack_o && wb_dat_o[4:0] == $past(auto_m);
  endproperty
  a_m_readback: assert property (p_m_readback) else $error("M read not automatic");

  property p_n_readback;
    @(posedge ref_clk) disable iff (!rst_n)
    req && !wb_we_i && hit(wb_adr_i, pclk_cfg_pkg::DIV_N_IDX)
      |=> wb_ack_o && wb_dat_o[7:0] == $past(sel_n);
  endproperty
  a_n_readback: assert property (p_n_readback) else $error("N read wrong");

  property p_ack_follows_req;
    @(posedge ref_clk) disable iff (!rst_n)
    req |=> wb_ack_o;
  endproperty
  a_ack_follows_req: assert property (p_ack_follows_req) else $error("request not acknowledged");

  property p_data_upper_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_data_upper_zero: assert property (p_data_upper_zero) else $error("upper read bits not zero");

  property p_term_auto;
    @(posedge ref_clk) disable iff (!rst_n)
    !termination_override ##1 !termination_override |-> term_enable == $past(auto_term_enable);
  endproperty
  a_term_auto: assert property (p_term_auto) else $error("termination not automatic");

  property p_term_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !wr |=> $stable(term_lanes_reg) && $stable(termination_override);
  endproperty
  a_term_hold: assert property (p_term_hold) else $error("termination bits changed without write");

  property p_n_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && hit(wb_adr_i, pclk_cfg_pkg::DIV_N_IDX) |=> div_n_reg == $past(wb_dat_i[7:0]);
  endproperty
  a_n_write: assert property (p_n_write) else $error("N value not stored");

  property p_m_read_ovr;
    @(posedge ref_clk) disable iff (!rst_n)
    req && !wb_we_i && hit(wb_adr_i, pclk_cfg_pkg::DIV_M_IDX) && divider_override
      |=> wb_dat_o[7:0] == {1'b1, 2'b00, $past(div_m_reg)};
  endproperty
  a_m_read_ovr: assert property (p_m_read_ovr) else $error("M read not written value");
endmodule // dsi_rx_term_pclk_cfg
`default_nettype wire

// ===== core/mn_divider.sv
`timescale 1ns/1ps
`default_nettype none
module mn_divider (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic [pclk_cfg_pkg::M_W-1:0] m_in,
  input wire logic [pclk_cfg_pkg::N_W-1:0] n_in,
  output logic pclk_en
);
  localparam int N_W = pclk_cfg_pkg::N_W;
  logic [pclk_cfg_pkg::N_W-1:0] m_reg;
  logic [pclk_cfg_pkg::N_W-1:0] n_reg;
  logic [pclk_cfg_pkg::N_W-1:0] acc_reg;
  logic [pclk_cfg_pkg::N_W:0] sum;
  logic wrap;
  logic idle;
  logic [N_W-1:0] residue;

  assign idle = (m_reg == '0) || (n_reg == '0);
  assign sum = {1'b0, acc_reg} + {1'b0, m_reg};
  assign wrap = src_tick && !idle && (sum >= {1'b0, n_reg});
  assign residue = N_W'(sum - {1'b0, n_reg});

  ////////////////////////////////////////////////////////////////
  // New settings taken only at a wrap or while idle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_reg <= '0;
      n_reg <= '0;
    end else if (wrap || idle) begin
      n_reg <= n_in;
      m_reg <= ({3'b000, m_in} > n_in) ? n_in : {3'b000, m_in};
    end
  end

  // Fractional accumulator, out rate = tick rate * min(M, N) / N
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      pclk_en <= 1'b0;
    end else begin
      pclk_en <= wrap;
      if (idle) begin
        acc_reg <= '0;
      end else if (wrap) begin
        // Residue dropped if it would reach or exceed a smaller new N
        acc_reg <= (residue >= n_in) ? '0 : residue;
      end else if (src_tick) begin
        acc_reg <= sum[pclk_cfg_pkg::N_W-1:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_acc_bounded;
    @(posedge ref_clk) disable iff (!rst_n)
    !idle |-> acc_reg < n_reg;
  endproperty
  a_acc_bounded: assert property (p_acc_bounded) else $error("accumulator reached N");

  property p_pulse_needs_tick;
    @(posedge ref_clk) disable iff (!rst_n)
    pclk_en |-> $past(src_tick) && !$past(idle);
  endproperty
  a_pulse_needs_tick: assert property (p_pulse_needs_tick) else $error("pixel enable without source tick");

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
    idle |=> !pclk_en;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pixel enable while divider idle");
endmodule // mn_divider
`default_nettype wire

// ===== core/pclk_cfg_pkg.sv
`default_nettype none
package pclk_cfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] TERM_IDX = 8'h38;
  localparam logic [7:0] DIV_M_IDX = 8'h3A;
  localparam logic [7:0] DIV_N_IDX = 8'h3B;
  localparam int ADDR_W = 10;
  // Termination register fields
  localparam int TERM_OVR_BIT = 6;
  localparam int TERM_LANES_W = 5;
  localparam logic [4:0] TERM_RESET = 5'h00;
  localparam logic TERM_OVR_RESET = 1'b0;
  // Divider M and N register fields
  localparam int DIV_OVR_BIT = 7;
  localparam int M_W = 5;
  localparam int N_W = 8;
  localparam logic DIV_OVR_RESET = 1'b0;
  localparam logic [4:0] M_RESET = 5'h00;
  localparam logic [7:0] N_RESET = 8'h00;
endpackage
`default_nettype wire
